// *** inc/dbs_pkg.sv ***
// Constants, field positions and state types for the two-word burst DDR SRAM port.
// Assumes one system clock that oversamples every pin clock many times over.
package dbs_pkg;

  // ==========================================================================
  // Geometry (wide variant: 4 M words of 36 bits as two 2 M halves)
  localparam int DATA_W     = 36;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int ADDR_W     = 22;
  localparam int HALF_AW    = ADDR_W - 1;
  localparam int HALF_DEPTH = 2 ** HALF_AW;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================================
  // Bit positions inside the synchronised pin vector
  localparam int P_K    = 0;
  localparam int P_KN   = 1;
  localparam int P_C    = 2;
  localparam int P_CN   = 3;
  localparam int P_LD   = 4;
  localparam int P_RW   = 5;
  localparam int P_MASK = 6;
  localparam int P_LSB  = 10;
  localparam int P_AHI  = 11;
  localparam int P_DQ   = 32;
  localparam int P_PLL_BYPASS_N = 68;
  localparam int SYNC_W = 69;

  // ==========================================================================
  // Read scheduling: output edges skipped before the first beat
  localparam int SCHED_W = 4;
  localparam logic [SCHED_W-1:0] SCHED_PLL    = 4'hC;  // Beats on edges 3 and 4
  localparam logic [SCHED_W-1:0] SCHED_LEGACY = 4'h6;  // Beats on edges 2 and 3
  localparam logic [SCHED_W-1:0] SCHED_RST    = 4'h0;

  // ==========================================================================
  // Single clock mode: cycles both output clocks must stay high
  localparam logic [6:0] SCM_CYCLES = 7'h40;
  localparam logic [6:0] SCM_RST    = 7'h00;

  // ==========================================================================
  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = {SYNC_W{1'b0}};
  localparam logic [DATA_W-1:0] DATA_RST = {DATA_W{1'b0}};
  localparam logic [ADDR_W-1:0] ADDR_RST = {ADDR_W{1'b0}};

  typedef enum logic [1:0] {WR_IDLE, WR_BEAT0, WR_BEAT1} dbs_wr_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WORD0, RD_WORD1} dbs_rd_state_t;

endpackage

// *** rtl/dbs_port.sv ***
// Two-word burst DDR SRAM port with its read-data FIFO.
// Assumes all pin clocks and pins are sampled by a much faster system clock.
`timescale 1ns/1ps

// ============================================================================
// FIFO of parameterised width and depth
module dbs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys_i,  // System clock
  input  wire logic             rst_i,      // Async reset, high
  input  wire logic             ce_i,       // Clock enable
  input  wire logic             in_valid_i, // Push request
  output logic                  in_ready_o, // Not full
  input  wire logic [WIDTH-1:0] in_data_i,  // Push data
  output logic                  out_valid_o,// Not empty
  input  wire logic             out_ready_i,// Pop request
  output logic      [WIDTH-1:0] out_data_o  // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             do_push;
  logic             do_pop;

  // Full and empty from pointers with wrap bit
  assign in_ready_o  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = store[rd_ptr[PW-1:0]];
  assign do_push     = ce_i && in_valid_i && in_ready_o;
  assign do_pop      = ce_i && out_ready_i && out_valid_o;

  // Storage write
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      store[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module dbs_port
  import dbs_pkg::*;
(
  input  wire logic              clk_sys_i,          // System clock, 250 MHz
  input  wire logic              rst_i,              // Async reset, high
  input  wire logic              ce_i,               // Clock enable, freezes all
  input  wire logic              in_clk_i,           // Positive input clock pin
  input  wire logic              in_clk_n_i,         // Negative input clock pin
  input  wire logic              out_clk_i,          // Positive output data clock pin
  input  wire logic              out_clk_n_i,        // Negative output data clock pin
  input  wire logic              load_strobe_n_i,    // Load strobe, low
  input  wire logic              read_write_i,       // High read, low write
  input  wire logic [LANES-1:0]  byte_lane_mask_n_i, // Lane write masks, low
  input  wire logic              burst_lsb_addr_i,   // Burst counter start bit
  input  wire logic [HALF_AW-1:0] addr_i,            // Upper address bits
  input  wire logic              pll_bypass_n_i,     // High: 1.5-cycle latency
  input  wire logic [DATA_W-1:0] dq_i,               // Data pin level in
  output logic      [DATA_W-1:0] dq_o,               // Data pin drive value
  output logic                   dq_oe_o,            // Data pin drive enable
  output logic                   return_strobe_o,    // Positive echo clock
  output logic                   return_strobe_n_o   // Negative echo clock
);

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pin_vec;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] agreed;
  logic [SYNC_W-1:0] next_agreed;
  logic [SYNC_W-1:0] same;

  assign pin_vec = {pll_bypass_n_i, dq_i, addr_i, burst_lsb_addr_i, byte_lane_mask_n_i,
                    read_write_i, load_strobe_n_i, out_clk_n_i, out_clk_i,
                    in_clk_n_i, in_clk_i};

  // Three-stage capture of every pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
    end else if (ce_i) begin
      sync1 <= pin_vec;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A bit changes only once stages two and three agree
  assign same        = ~(sync2 ^ sync3);
  assign next_agreed = (sync3 & same) | (agreed & ~same);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      agreed <= SYNC_RST;
    end else if (ce_i) begin
      agreed <= next_agreed;
    end
  end

  // ==========================================================================
  // Edge detection and clock mode
  logic       k_rise;
  logic       kn_rise;
  logic       c_rise;
  logic       cn_rise;
  logic       single_mode;
  logic [6:0] scm_count;
  logic       out_edge;

  assign k_rise  = next_agreed[P_K]  && !agreed[P_K];
  assign kn_rise = next_agreed[P_KN] && !agreed[P_KN];
  assign c_rise  = next_agreed[P_C]  && !agreed[P_C];
  assign cn_rise = next_agreed[P_CN] && !agreed[P_CN];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      scm_count   <= SCM_RST;
      single_mode <= 1'b0;
    end else if (ce_i) begin
      if (!(agreed[P_C] && agreed[P_CN])) begin
        scm_count   <= SCM_RST;
        single_mode <= 1'b0;
      end else if (scm_count != SCM_CYCLES) begin
        scm_count <= scm_count + 7'h01;
      end else begin
        single_mode <= 1'b1;
      end
    end
  end

  assign out_edge = single_mode ? (k_rise || kn_rise) : (c_rise || cn_rise);

  // ==========================================================================
  // Command decode on the positive input clock
  logic              rd_cmd;
  logic              wr_cmd;
  logic [ADDR_W-1:0] pin_addr;

  assign pin_addr = {agreed[P_AHI +: HALF_AW], agreed[P_LSB]};
  // Levels at the K edge; a K high after reset counts as a rise and can load
  assign rd_cmd = k_rise && !next_agreed[P_LD] && next_agreed[P_RW];
  assign wr_cmd = k_rise && !next_agreed[P_LD] && !next_agreed[P_RW];

  // ==========================================================================
  // Storage: even and odd burst words in separate halves
  logic [DATA_W-1:0] mem_even [0:HALF_DEPTH-1];
  logic [DATA_W-1:0] mem_odd  [0:HALF_DEPTH-1];

  // Word at a full address, half picked by the low bit
  function automatic logic [DATA_W-1:0] dbs_fetch(input logic [ADDR_W-1:0] a);
    dbs_fetch = a[0] ? mem_odd[a[ADDR_W-1:1]] : mem_even[a[ADDR_W-1:1]];
  endfunction

  // Second burst address: one-bit counter wraps within the pair
  function automatic logic [ADDR_W-1:0] dbs_next_addr(input logic [ADDR_W-1:0] a);
    dbs_next_addr = {a[ADDR_W-1:1], ~a[0]};
  endfunction

  // ==========================================================================
  // Write engine
  dbs_wr_state_t     wr_state;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_beat;
  logic [ADDR_W-1:0] wr_target;

  // Beat 0 on K-bar, beat 1 on the next K
  assign wr_beat   = ((wr_state == WR_BEAT0) && kn_rise) || ((wr_state == WR_BEAT1) && k_rise);
  assign wr_target = (wr_state == WR_BEAT1) ? dbs_next_addr(wr_addr) : wr_addr;

  // Two beats from the loaded address
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_state <= WR_IDLE;
      wr_addr  <= ADDR_RST;
    end else if (ce_i) begin
      if (wr_cmd) begin
        wr_state <= WR_BEAT0;
        wr_addr  <= pin_addr;
      end else begin
        case (wr_state)
          WR_BEAT0: begin
            if (kn_rise) begin
              wr_state <= WR_BEAT1;
            end
          end
          WR_BEAT1: begin
            if (k_rise) begin
              wr_state <= WR_IDLE;
            end
          end
          default: wr_state <= WR_IDLE;
        endcase
      end
    end
  end

  // Array write into the half named by the low bit
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && wr_beat) begin
      for (int l = 0; l < LANES; l++) begin
        // Lane written only when its mask is low
        if (!agreed[P_MASK + l]) begin
          if (wr_target[0]) begin
            mem_odd[wr_target[ADDR_W-1:1]][l*LANE_W +: LANE_W] <= agreed[P_DQ + l*LANE_W +: LANE_W];
          end else begin
            mem_even[wr_target[ADDR_W-1:1]][l*LANE_W +: LANE_W] <= agreed[P_DQ + l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // ==========================================================================
  // Read fetch into the FIFO
  dbs_rd_state_t     rd_state;
  logic [ADDR_W-1:0] rd_addr;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [DATA_W-1:0] fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [DATA_W-1:0] fifo_out_data;

  // Word of the current burst step, refreshed on any array write too
  assign fifo_in_valid = (rd_state != RD_IDLE);
  always_comb fifo_in_data = dbs_fetch((rd_state == RD_WORD1) ? dbs_next_addr(rd_addr) : rd_addr);

  // Fetch both words, stalled by a full FIFO
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state <= RD_IDLE;
      rd_addr  <= ADDR_RST;
    end else if (ce_i) begin
      case (rd_state)
        RD_IDLE: begin
          if (rd_cmd) begin
            rd_state <= RD_WORD0;
            rd_addr  <= pin_addr;
          end
        end
        RD_WORD0: begin
          if (fifo_in_ready) begin
            rd_state <= RD_WORD1;
          end
        end
        RD_WORD1: begin
          if (fifo_in_ready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // Read data buffer
  dbs_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // ==========================================================================
  // Output beat schedule, one bit per future output edge
  logic [SCHED_W-1:0] sched;
  logic [SCHED_W-1:0] next_sched;
  logic               beat_due;

  assign beat_due = out_edge && sched[0];
  assign fifo_pop = beat_due && fifo_out_valid;

  // Latency picked by the PLL bypass level
  always_comb begin
    next_sched = out_edge ? (sched >> 1) : sched;
    if (rd_cmd) begin
      next_sched = next_sched | (agreed[P_PLL_BYPASS_N] ? SCHED_PLL : SCHED_LEGACY);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sched <= SCHED_RST;
    end else if (ce_i) begin
      sched <= next_sched;
    end
  end

  // Drive a beat per due edge, release on other output edges
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o    <= DATA_RST;
      dq_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (beat_due) begin
        dq_o    <= fifo_out_data;
        dq_oe_o <= 1'b1;
      end else if (out_edge) begin
        dq_oe_o <= 1'b0;
      end
    end
  end

  // Echo clocks follow the output clock source
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      return_strobe_o   <= 1'b0;
      return_strobe_n_o <= 1'b0;
    end else if (ce_i) begin
      return_strobe_o   <= single_mode ? agreed[P_K]  : agreed[P_C];
      return_strobe_n_o <= single_mode ? agreed[P_KN] : agreed[P_CN];
    end
  end

endmodule

// *** testbench/dbs_ctrl_model.sv ***
// Memory controller model: pin clocks and the shared data wire.
// Assumes the bench drives commands on the phase count given here.
`timescale 1ns/1ps
module dbs_ctrl_model (
  input  wire logic        clk_sys_i,  // System clock
  input  wire logic        rst_i,      // Async reset, high
  input  wire logic        single_i,   // Hold output clocks high
  input  wire logic        drv_en_i,   // Controller drives write data
  input  wire logic [35:0] drv_data_i, // Write data
  input  wire logic [35:0] dev_dq_i,   // Device drive value
  input  wire logic        dev_oe_i,   // Device drive enable
  output logic             k_o,        // Positive input clock
  output logic             kn_o,       // Negative input clock
  output logic             c_o,        // Positive output clock
  output logic             cn_o,       // Negative output clock
  output logic [4:0]       ph_o,       // Phase within a pin clock period
  output logic [35:0]      dq_o        // Resolved data wire
);
  logic [35:0] last; // Last wire level

  // ==========================================================================
  // Phase count and wire history
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ph_o <= 5'h00;
      last <= 36'h0;
    end else begin
      ph_o <= ph_o + 5'h01;
      last <= dq_o;
    end
  end
  assign k_o = ~ph_o[4];
  assign kn_o = ph_o[4];
  assign c_o = single_i | k_o;
  assign cn_o = single_i | kn_o;
  // Undriven wire wanders so stale data never looks valid
  assign dq_o = dev_oe_i ? dev_dq_i : (drv_en_i ? drv_data_i : ~last);
endmodule

// *** testbench/dbs_port_sva.sv ***
// Checker for the burst SRAM port, watching its ports only.
// Assumes pin clocks many times slower than clk_sys_i.
`timescale 1ns/1ps
module dbs_port_chk
  import dbs_pkg::*;
(
  input  wire logic               clk_sys_i,          // System clock
  input  wire logic               rst_i,              // Async reset, high
  input  wire logic               ce_i,               // Clock enable
  input  wire logic               in_clk_i,           // Positive input clock
  input  wire logic               in_clk_n_i,         // Negative input clock
  input  wire logic               out_clk_i,          // Positive output clock
  input  wire logic               out_clk_n_i,        // Negative output clock
  input  wire logic               load_strobe_n_i,    // Load strobe, low
  input  wire logic               read_write_i,       // High read
  input  wire logic [LANES-1:0]   byte_lane_mask_n_i, // Lane masks, low
  input  wire logic               burst_lsb_addr_i,   // Address bit 0
  input  wire logic [HALF_AW-1:0] addr_i,             // Upper address
  input  wire logic               pll_bypass_n_i,     // Latency select
  input  wire logic [DATA_W-1:0]  dq_i,               // Data pin level
  input  wire logic [DATA_W-1:0]  dq_o,               // Data drive value
  input  wire logic               dq_oe_o,            // Data drive enable
  input  wire logic               return_strobe_o,    // Positive echo
  input  wire logic               return_strobe_n_o   // Negative echo
);
  logic [3:0] clk_q;                              // Pin clock history
  logic [7:0] pos_age, neg_age, edge_age, rd_age; // Cycles since events
  logic       pos_up, neg_up;                     // Pin clock rises

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // ==========================================================================
  // Ages of the last pin clock rises and read commands
  assign pos_up = (in_clk_i & ~clk_q[0]) | (out_clk_i & ~clk_q[2]);
  assign neg_up = (in_clk_n_i & ~clk_q[1]) | (out_clk_n_i & ~clk_q[3]);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_q <= 4'h0;
      {pos_age, neg_age, edge_age, rd_age} <= 32'hFFFFFFFF;
    end else begin
      clk_q <= {out_clk_n_i, out_clk_i, in_clk_n_i, in_clk_i};
      pos_age <= pos_up ? 8'h00 : inc(pos_age);
      neg_age <= neg_up ? 8'h00 : inc(neg_age);
      edge_age <= (pos_up | neg_up) ? 8'h00 : inc(edge_age);
      rd_age <= (!load_strobe_n_i && read_write_i) ? 8'h00 : inc(rd_age);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Properties
  property p_oe_after_read; $rose(dq_oe_o) |-> rd_age < 8'h78; endproperty
  a_oe_after_read: assert property (p_oe_after_read)
    else $error("Data drive without a recent read");
  property p_idle_released; rd_age == 8'hFF |-> !dq_oe_o; endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("Data pins driven with no read");
  property p_beat_on_edge;
    ($changed(dq_o) && dq_oe_o) |-> edge_age inside {[8'h01:8'h08]};
  endproperty
  a_beat_on_edge: assert property (p_beat_on_edge)
    else $error("Read beat not tied to an output clock edge");
  property p_drop_on_edge; $fell(dq_oe_o) |-> edge_age inside {[8'h01:8'h08]}; endproperty
  a_drop_on_edge: assert property (p_drop_on_edge)
    else $error("Drive released off an output clock edge");
  property p_echo_pos; $rose(return_strobe_o) |-> pos_age inside {[8'h01:8'h08]}; endproperty
  a_echo_pos: assert property (p_echo_pos)
    else $error("Positive echo rose without a clock rise");
  property p_echo_neg; $rose(return_strobe_n_o) |-> neg_age inside {[8'h01:8'h08]}; endproperty
  a_echo_neg: assert property (p_echo_neg)
    else $error("Negative echo rose without a clock rise");
  property p_rst_release; $fell(rst_i) |-> !dq_oe_o [*8]; endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("Data pins driven just after reset");
  property p_echo_rst; $fell(rst_i) |-> !return_strobe_o && !return_strobe_n_o; endproperty
  a_echo_rst: assert property (p_echo_rst)
    else $error("Echo clocks not low after reset");

  c_read: cover property ($rose(dq_oe_o));
  c_write: cover property (!load_strobe_n_i && !read_write_i);
  c_echo: cover property ($rose(return_strobe_n_o));
endmodule

bind dbs_port dbs_port_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .in_clk_i(in_clk_i),
  .in_clk_n_i(in_clk_n_i), .out_clk_i(out_clk_i), .out_clk_n_i(out_clk_n_i),
  .load_strobe_n_i(load_strobe_n_i), .read_write_i(read_write_i),
  .byte_lane_mask_n_i(byte_lane_mask_n_i), .burst_lsb_addr_i(burst_lsb_addr_i),
  .addr_i(addr_i), .pll_bypass_n_i(pll_bypass_n_i), .dq_i(dq_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .return_strobe_o(return_strobe_o),
  .return_strobe_n_o(return_strobe_n_o)
);

// *** testbench/dbs_port_tb.sv ***
// Self-checking bench for the burst SRAM port.
// Assumes the controller model sets pin clock timing.
`timescale 1ns/1ps
module dbs_port_tb
  import dbs_pkg::*;
;
  logic clk_sys_i, rst_i, load_strobe_n, rw, lsb, pll_bypass_n, single, drv_en;
  logic [3:0]  byte_lane_mask_n; // Lane masks
  logic [20:0] addr;             // Upper address
  logic [35:0] drv_data, m0, m1; // Write data, merged words
  logic k, kn, c, cn, dq_oe, rs, rsn;
  logic [4:0]  ph;               // Pin clock phase
  logic [35:0] dq_w, dq_o;       // Wire and drive value
  int err_total, n_compared;

  dbs_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .single_i(single),
    .drv_en_i(drv_en), .drv_data_i(drv_data), .dev_dq_i(dq_o), .dev_oe_i(dq_oe),
    .k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn), .ph_o(ph), .dq_o(dq_w));
  dbs_port dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .in_clk_i(k),
    .in_clk_n_i(kn), .out_clk_i(c), .out_clk_n_i(cn), .load_strobe_n_i(load_strobe_n),
    .read_write_i(rw), .byte_lane_mask_n_i(byte_lane_mask_n), .burst_lsb_addr_i(lsb),
    .addr_i(addr), .pll_bypass_n_i(pll_bypass_n), .dq_i(dq_w), .dq_o(dq_o),
    .dq_oe_o(dq_oe), .return_strobe_o(rs), .return_strobe_n_o(rsn));

  // ==========================================================================
  // Helpers
  task automatic summarize;
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic see(input string nm, input logic [35:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic at(input logic [4:0] p);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (ph !== p && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40) begin
      $display("Error phase_wait expected %h seen %h", p, ph);
      err_total++;
      summarize;
    end
  endtask
  task automatic half;
    repeat (16) @(posedge clk_sys_i);
  endtask
  function automatic logic [35:0] merge(input logic [35:0] old, nw, input logic [3:0] m);
    merge = old;
    for (int l = 0; l < 4; l++) if (!m[l]) merge[l*9 +: 9] = nw[l*9 +: 9];
  endfunction
  task automatic wr(input logic [21:0] a, input logic [35:0] w0, w1, input logic [3:0] k0, k1);
    at(5'h18);
    load_strobe_n <= 1'b0;
    rw <= 1'b0;
    {addr, lsb} <= a;
    at(5'h08);
    load_strobe_n <= 1'b1;
    drv_en <= 1'b1;
    drv_data <= w0;
    byte_lane_mask_n <= k0;
    at(5'h18);
    drv_data <= w1;
    byte_lane_mask_n <= k1;
    at(5'h08);
    drv_en <= 1'b0;
    byte_lane_mask_n <= 4'hF;
  endtask
  task automatic rd(input logic [21:0] a, input logic [35:0] e0, e1);
    at(5'h18);
    load_strobe_n <= 1'b0;
    rw <= 1'b1;
    {addr, lsb} <= a;
    at(5'h08);
    load_strobe_n <= 1'b1;
    half;
    see("drive_idle", 36'h0, {35'h0, dq_oe});
    half;
    if (pll_bypass_n) begin
      see("drive_idle", 36'h0, {35'h0, dq_oe});
      half;
    end
    see("drive_on", 36'h1, {35'h0, dq_oe});
    see("word0", e0, dq_o);
    half;
    see("word1", e1, dq_o);
    half;
    see("drive_off", 36'h0, {35'h0, dq_oe});
  endtask
  task automatic t_echo;
    at(5'h08);
    see("echo_pos", 36'h1, {35'h0, rs});
    see("echo_neg", 36'h0, {35'h0, rsn});
    at(5'h18);
    see("echo_pos", 36'h0, {35'h0, rs});
    see("echo_neg", 36'h1, {35'h0, rsn});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_basic;
    t_echo;
    wr(22'h000104, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
    rd(22'h000104, 36'h123456789, 36'hFEDCBA987);
  endtask
  task automatic t_odd;
    wr(22'h2AAAA3, 36'hA5A5A5A5A, 36'h5A5A5A5A5, 4'h0, 4'h0);
    rd(22'h2AAAA2, 36'h5A5A5A5A5, 36'hA5A5A5A5A);
  endtask
  task automatic t_mask;
    m0 = merge(36'h123456789, 36'hFFFFFFFFF, 4'hA);
    m1 = merge(36'hFEDCBA987, 36'h000000000, 4'h5);
    wr(22'h000104, 36'hFFFFFFFFF, 36'h000000000, 4'hA, 4'h5);
    rd(22'h000104, m0, m1);
  endtask
  task automatic t_deselect;
    at(5'h18);
    rw <= 1'b0;
    {addr, lsb} <= 22'h000104;
    drv_en <= 1'b1;
    drv_data <= 36'h0;
    byte_lane_mask_n <= 4'h0;
    repeat (4) half;
    drv_en <= 1'b0;
    byte_lane_mask_n <= 4'hF;
    rd(22'h000104, m0, m1);
  endtask
  task automatic t_legacy;
    pll_bypass_n <= 1'b0;
    rd(22'h2AAAA2, 36'h5A5A5A5A5, 36'hA5A5A5A5A);
    pll_bypass_n <= 1'b1;
  endtask
  task automatic t_single;
    single <= 1'b1;
    repeat (8) half;
    t_echo;
    rd(22'h000104, m0, m1);
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    rst_i = 1'b1;
    load_strobe_n = 1'b1;
    rw = 1'b0;
    lsb = 1'b0;
    addr = 21'h0;
    pll_bypass_n = 1'b1;
    single = 1'b0;
    drv_en = 1'b0;
    drv_data = 36'h0;
    byte_lane_mask_n = 4'hF;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_basic;
    t_odd;
    t_mask;
    t_deselect;
    t_legacy;
    t_single;
    summarize;
  end
endmodule
